// [common/qacs_pkg.sv]
`default_nettype none
package qacs_pkg;

    // ----------------------------------------
    // control word layout
    // ----------------------------------------
    localparam int           CTL_W     = 8;
    localparam int           SEL_TOP   = 5;
    localparam int           SEL_MID   = 4;
    localparam int           SEL_LO    = 3;
    localparam logic [1:0]   CHAN_RST  = 2'h0;

    // ----------------------------------------
    // conversion timing, in serial clock edges
    // ----------------------------------------
    localparam logic [4:0]   EDGE_ONE        = 5'h01;
    localparam logic [4:0]   CONV_CLKS       = 5'h10;
    localparam logic [4:0]   HOLD_FALL       = 5'h04;
    localparam logic [4:0]   CTL_RISES       = 5'h08;
    localparam logic [4:0]   SAR_FIRST_RISE  = 5'h04;
    localparam logic [4:0]   SAR_LAST_RISE   = 5'h0b;
    localparam logic [4:0]   DOUT_FIRST_FALL = 5'h05;
    localparam logic [4:0]   DOUT_LAST_FALL  = 5'h0c;

    // ----------------------------------------
    // result format
    // ----------------------------------------
    localparam int           RES_W     = 8;
    localparam int           RES_CODES = 256;
    localparam logic [7:0]   SAR_TRIAL = 8'h80;
    localparam logic [7:0]   RES_RST   = 8'h00;

    // ----------------------------------------
    // pin synchroniser lanes
    // ----------------------------------------
    localparam int           SYNC_W    = 4;
    localparam int           LN_SCLK   = 0;
    localparam int           LN_CS     = 1;
    localparam int           LN_DIN    = 2;
    localparam int           LN_COMP   = 3;
    localparam logic [3:0]   SYNC_RST  = 4'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONVERT, ST_SLEEP} qacs_state_t;

endpackage
`default_nettype wire

// [core/qacs_core.sv]
// Overview of operation
// - control word bits 7-6 and 2-0 never affect converter behaviour
// - bits 5-3 choose the input sampled in the following conversion
// - bit 5 ignored; 00,01,10,11 select inputs one to four
// - result is unsigned straight binary with mid-LSB code transitions
// - result spans 256 codes, one LSB is supply over 256
// - powered from the 1st to the 16th falling edge while frame select low, powered down while it is high
// - power-down from 16th falling clock edge to next 1st falling edge
// - each conversion takes 16 clocks, back to back allowed
// - conversions repeat as long as frame select stays low
// - continuous throughput is serial clock over 16
// - control word captured on first eight rising edges of conversion
// - track three clocks, convert twelve, result MSB first from clock 5
// - first conversion after power-up samples input one
`timescale 1ns/100ps
`default_nettype none
module qacs_core
    import qacs_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_b,
    // serial link pins
    input  wire logic              sclk,
    input  wire logic              cs_b,
    input  wire logic              din,
    output logic                   dout,
    output logic                   dout_oe,
    // converter core
    input  wire logic              comp_above,
    output logic      [3:0]        mux_sel,
    output logic                   track,
    output logic                   convert,
    output logic                   power_up,
    output logic      [RES_W-1:0]  dac_code,
    // result
    output logic      [RES_W-1:0]  result,
    output logic                   result_valid
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [2:0] sar_idx(input logic [4:0] n);
        sar_idx = 3'(SAR_LAST_RISE - n);
    endfunction

    function automatic logic [4:0] next_edge(input logic [4:0] n);
        next_edge = (n == CONV_CLKS || n == 5'h00) ? EDGE_ONE : 5'(n + EDGE_ONE);
    endfunction

    typedef struct packed {
        qacs_state_t        state;
        logic [4:0]         fall_cnt;
        logic [4:0]         rise_cnt;
        logic [CTL_W-1:0]   ctl_sr;
        logic [1:0]         chan;
        logic [RES_W-1:0]   sar;
        logic [RES_W-1:0]   result;
        logic               res_vld;
        logic               dout;
        logic               dout_oe;
        logic               sclk_d;
        logic               cs_d;
    } qacs_core_t;

    qacs_core_t           s_r;
    qacs_core_t           s_nxt;
    logic [SYNC_W-1:0]    pins_s;
    logic                 sclk_s;
    logic                 cs_s;
    logic                 din_s;
    logic                 comp_s;
    logic                 frame;
    logic                 fall_evt;
    logic                 rise_evt;
    logic [4:0]           fall_no;
    logic [4:0]           rise_no;
    logic [2:0]           bit_sel;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    qacs_sync #(
        .W       (SYNC_W),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .clock    (clock),
        .rst_b    (rst_b),
        .async_in ({comp_above, din, cs_b, sclk}),
        .sync_out (pins_s)
    );

    assign sclk_s = pins_s[LN_SCLK];
    assign cs_s   = pins_s[LN_CS];
    assign din_s  = pins_s[LN_DIN];
    assign comp_s = pins_s[LN_COMP];

    // ----------------------------------------
    // edge detection
    // ----------------------------------------
    // sclk is gated by frame select; a select fall with sclk low is the first fall
    assign frame    = ~cs_s;
    assign fall_evt = frame & ~sclk_s & (s_r.sclk_d | s_r.cs_d);
    assign rise_evt = frame & sclk_s & ~s_r.sclk_d;
    assign fall_no  = next_edge(s_r.fall_cnt);
    assign rise_no  = next_edge(s_r.rise_cnt);
    assign bit_sel  = sar_idx(rise_no);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb
    begin
        s_nxt         = s_r;
        s_nxt.sclk_d  = sclk_s;
        s_nxt.cs_d    = cs_s;
        s_nxt.dout_oe = frame;
        s_nxt.res_vld = 1'b0;
        if (!frame)
        begin
            s_nxt.state    = ST_IDLE;
            s_nxt.fall_cnt = 5'h00;
            s_nxt.rise_cnt = 5'h00;
            s_nxt.dout     = 1'b0;
        end
        else
        begin
            if (fall_evt)
            begin
                s_nxt.fall_cnt = fall_no;
                s_nxt.dout     = 1'b0;
                case (fall_no)
                    EDGE_ONE:  s_nxt.state = ST_TRACK;
                    HOLD_FALL:
                    begin
                        s_nxt.state = ST_CONVERT;
                        s_nxt.sar   = SAR_TRIAL;
                    end
                    CONV_CLKS: s_nxt.state = ST_SLEEP;
                    default:   s_nxt.state = s_r.state;
                endcase
                if (fall_no >= DOUT_FIRST_FALL && fall_no <= DOUT_LAST_FALL)
                begin
                    s_nxt.dout = s_r.sar[sar_idx(5'(fall_no - EDGE_ONE))];
                end
            end
            if (rise_evt)
            begin
                s_nxt.rise_cnt = rise_no;
                if (rise_no <= CTL_RISES)
                begin
                    s_nxt.ctl_sr = {s_r.ctl_sr[CTL_W-2:0], din_s};
                end
                if (rise_no >= SAR_FIRST_RISE && rise_no <= SAR_LAST_RISE)
                begin
                    s_nxt.sar[bit_sel] = comp_s;
                    if (bit_sel != 3'h0)
                    begin
                        s_nxt.sar[3'(bit_sel - 3'h1)] = 1'b1;
                    end
                end
                if (rise_no == SAR_LAST_RISE)
                begin
                    s_nxt.result  = {s_r.sar[RES_W-1:1], comp_s};
                    s_nxt.res_vld = 1'b1;
                end
                if (rise_no == CONV_CLKS)
                begin
                    s_nxt.chan = s_r.ctl_sr[SEL_MID:SEL_LO];
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_r          <= '0;
            s_r.state    <= ST_IDLE;
            s_r.chan     <= CHAN_RST;
            s_r.sar      <= RES_RST;
            s_r.result   <= RES_RST;
            s_r.cs_d     <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign dout         = s_r.dout;
    assign dout_oe      = s_r.dout_oe;
    assign mux_sel      = 4'(4'h1 << s_r.chan);
    assign track        = (s_r.state == ST_TRACK);
    assign convert      = (s_r.state == ST_CONVERT);
    assign power_up     = track | convert;
    assign dac_code     = s_r.sar;
    assign result       = s_r.result;
    assign result_valid = s_r.res_vld;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_chan_latch: assert property (@(posedge clock) disable iff (!rst_b)
        (rise_evt && rise_no == CONV_CLKS) |=> (s_r.chan == $past(s_r.ctl_sr[SEL_MID:SEL_LO])))
        else $error("channel not latched at conversion end");

    a_chan_steady: assert property (@(posedge clock) disable iff (!rst_b)
        (s_r.state == ST_TRACK) |=> $stable(mux_sel) || (s_r.state != ST_TRACK))
        else $error("input select moved during tracking");

    a_sel_onehot: assert property (@(posedge clock) disable iff (!rst_b)
        $onehot(mux_sel) && mux_sel[s_r.chan])
        else $error("input select decode wrong");

    a_frame_power: assert property (@(posedge clock) disable iff (!rst_b)
        cs_s |=> !power_up)
        else $error("powered while frame select high");

    a_sleep_entry: assert property (@(posedge clock) disable iff (!rst_b)
        (fall_evt && fall_no == CONV_CLKS) |=> !power_up ##1 (!power_up || fall_evt))
        else $error("no power-down after sixteenth fall");

    a_back_to_back: assert property (@(posedge clock) disable iff (!rst_b)
        (fall_evt && s_r.fall_cnt == CONV_CLKS) |=> (s_r.state == ST_TRACK && s_r.fall_cnt == EDGE_ONE))
        else $error("next conversion did not start");

    a_hold_start: assert property (@(posedge clock) disable iff (!rst_b)
        (fall_evt && fall_no == HOLD_FALL) |=> convert && dac_code == SAR_TRIAL)
        else $error("hold not entered on fourth fall");

    a_ctl_shift: assert property (@(posedge clock) disable iff (!rst_b)
        (rise_evt && rise_no <= CTL_RISES) |=> (s_r.ctl_sr[0] == $past(din_s)))
        else $error("control bit not captured");

    a_dout_hiz: assert property (@(posedge clock) disable iff (!rst_b)
        cs_s ##1 cs_s |-> !dout_oe && !dout)
        else $error("data output driven outside frame");

    a_msb_first: assert property (@(posedge clock) disable iff (!rst_b)
        (fall_evt && fall_no == DOUT_FIRST_FALL) |=> (dout == $past(s_r.sar[RES_W-1])))
        else $error("msb not shifted on fifth fall");

    a_valid_pulse: assert property (@(posedge clock) disable iff (!rst_b)
        (rise_evt && rise_no == SAR_LAST_RISE) |=> result_valid)
        else $error("no result pulse after last trial");

    a_valid_single: assert property (@(posedge clock) disable iff (!rst_b)
        result_valid |=> !result_valid)
        else $error("result pulse longer than one cycle");

    a_result_hold: assert property (@(posedge clock) disable iff (!rst_b)
        !result_valid |-> $stable(result))
        else $error("result changed without pulse");

    a_result_final: assert property (@(posedge clock) disable iff (!rst_b)
        (rise_evt && rise_no == SAR_LAST_RISE) |=> (result == dac_code))
        else $error("result differs from final trial code");

    a_track_start: assert property (@(posedge clock) disable iff (!rst_b)
        (fall_evt && fall_no == EDGE_ONE) |=> (track && !convert))
        else $error("track not entered on first fall");

    a_convert_span: assert property (@(posedge clock) disable iff (!rst_b)
        (fall_evt && fall_no == CONV_CLKS) |-> convert)
        else $error("conversion ended before sixteenth fall");

    a_ctl_frozen: assert property (@(posedge clock) disable iff (!rst_b)
        (rise_evt && rise_no > CTL_RISES) |=> $stable(s_r.ctl_sr))
        else $error("control word shifted after eighth rise");

    a_dout_drive: assert property (@(posedge clock) disable iff (!rst_b)
        !cs_s ##1 !cs_s |-> dout_oe)
        else $error("data output not driven in frame");

    a_dout_quiet: assert property (@(posedge clock) disable iff (!rst_b)
        (fall_evt && (fall_no < DOUT_FIRST_FALL || fall_no > DOUT_LAST_FALL)) |=> !dout)
        else $error("data output high outside result bits");

    a_chan_hold: assert property (@(posedge clock) disable iff (!rst_b)
        !(rise_evt && rise_no == CONV_CLKS) |=> $stable(s_r.chan))
        else $error("channel changed inside a conversion");

    a_sleep_hold: assert property (@(posedge clock) disable iff (!rst_b)
        (s_r.state == ST_SLEEP && frame && !fall_evt) |=> (s_r.state == ST_SLEEP))
        else $error("left sleep without a falling edge");

    a_sleep_wake: assert property (@(posedge clock) disable iff (!rst_b)
        (s_r.state == ST_SLEEP && fall_evt) |=> track)
        else $error("no wake into track after sleep");

    a_frame_drop: assert property (@(posedge clock) disable iff (!rst_b)
        !frame |=> (s_r.fall_cnt == 5'h00 && s_r.rise_cnt == 5'h00))
        else $error("edge counters kept outside frame");

endmodule // qacs_core
`default_nettype wire

// [core/qacs_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module qacs_sync
    import qacs_pkg::*;
#(
    parameter int              W       = SYNC_W,
    parameter logic [W-1:0]    RST_VAL = SYNC_RST
)(
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst_b,
    // lanes
    input  wire logic [W-1:0]  async_in,
    output logic      [W-1:0]  sync_out
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } qacs_sync_t;

    qacs_sync_t s_r;
    qacs_sync_t s_nxt;

    always_comb
    begin
        s_nxt.stage1 = async_in;
        s_nxt.stage2 = s_r.stage1;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_r <= {RST_VAL, RST_VAL};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign sync_out = s_r.stage2;

endmodule // qacs_sync
`default_nettype wire

// [verif/qacs_host.sv]
`timescale 1ns/100ps
`default_nettype none
module qacs_host
    import qacs_pkg::*;
(
    // clock
    input  wire logic       clock,
    // serial link pins
    output var  logic       sclk,
    output var  logic       cs_b,
    output var  logic       din,
    input  wire logic       dout,
    // phase strobe for the bench
    output var  logic       smp,
    output var  logic [4:0] step
);
    initial
    begin
        sclk = 1'b0;
        cs_b = 1'b1;
        din  = 1'b0;
        smp  = 1'b0;
        step = 5'h00;
    end

    // half period of 5 clocks keeps sclk far below its ceiling
    task automatic half();
        repeat (5) @(posedge clock);
        #1;
    endtask

    task automatic frame_on();
        half();
        cs_b = 1'b0;
    endtask

    task automatic frame_off();
        half();
        cs_b = 1'b1;
        din  = ~din;
    endtask

    // n rising edges; n below 16 cuts a conversion short
    task automatic conv(input logic [7:0] ctl, input int n, output logic [7:0] got);
        got = 8'h00;
        for (int i = 1; i <= n; i++)
        begin
            din = (i <= 8) ? ctl[8-i] : ~din;
            half();
            step = 5'(i);
            smp  = 1'b1;
            if (i >= 5 && i <= 12)
                got[12-i] = dout;
            sclk = 1'b1;
            half();
            smp  = 1'b0;
            sclk = 1'b0;
        end
    endtask
endmodule // qacs_host
`default_nettype wire

// [verif/quad_channel_adc_serial_control_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module quad_channel_adc_serial_control_tb
    import qacs_pkg::*;
;
    typedef struct packed { logic [7:0] ctl; logic [7:0] res; } qacs_row_t;

    logic       clock = 1'b0;
    logic       rst_b, sclk, cs_b, din, dout, dout_oe, comp_above;
    logic       track, convert, power_up, result_valid, smp;
    logic [3:0] mux_sel;
    logic [4:0] step;
    logic [7:0] dac_code, result;
    int         bad_count = 0;
    int         n_tests   = 0;
    int         pulses    = 0;
    qacs_row_t  rows [6]  = '{'{8'h08, 8'h00}, '{8'hf7, 8'hff}, '{8'h18, 8'h5a},
                              '{8'h20, 8'ha5}, '{8'hcf, 8'h00}, '{8'h10, 8'hff}};

    always #50 clock = ~clock;

    qacs_core uut (.clock(clock), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .din(din),
        .dout(dout), .dout_oe(dout_oe), .comp_above(comp_above), .mux_sel(mux_sel),
        .track(track), .convert(convert), .power_up(power_up), .dac_code(dac_code),
        .result(result), .result_valid(result_valid));

    qacs_host host (.clock(clock), .sclk(sclk), .cs_b(cs_b), .din(din), .dout(dout),
        .smp(smp), .step(step));

    // ----------------------------------------
    // analog inputs and checking
    // ----------------------------------------
    function automatic logic [7:0] level(input logic [3:0] sel);
        case (sel)
            4'h1:    return 8'h00;
            4'h2:    return 8'hff;
            4'h4:    return 8'h5a;
            4'h8:    return 8'ha5;
            default: return 8'h33;
        endcase
    endfunction

    always @(posedge clock)
    begin
        #1;
        comp_above = level(mux_sel) >= dac_code;
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(negedge clock)
    begin
        if (result_valid === 1'b1)
            pulses++;
        if (smp && step == 5'h02)
        begin
            chk("track", track, 8'h01);
            chk("power_up", power_up, 8'h01);
            chk("dout_oe", dout_oe, 8'h01);
        end
        if (smp && step == 5'h08)
            chk("convert", convert, 8'h01);
        if (smp && step == 5'h10)
            chk("sleep", power_up, 8'h00);
    end

    task automatic idle_chk();
        repeat (6) @(negedge clock);
        chk("dout_oe", dout_oe, 8'h00);
        chk("dout", dout, 8'h00);
        chk("power_up", power_up, 8'h00);
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        logic [7:0] got;
        rst_b      = 1'b0;
        comp_above = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        rst_b = 1'b1;
        idle_chk();
        chk("mux_sel", 8'(mux_sel), 8'h01);
        chk("result", result, 8'h00);
        $display("reset test done");
        host.frame_on();
        foreach (rows[i])
        begin
            host.conv(rows[i].ctl, 16, got);
            chk("dout", got, rows[i].res);
            chk("result", result, rows[i].res);
            chk("dac_code", dac_code, rows[i].res);
            $display("row %0d done", i);
        end
        host.frame_off();
        idle_chk();
        chk("pulses", 8'(pulses), 8'h06);
        $display("back to back test done");
        host.frame_on();
        host.conv(8'h08, 8, got);
        host.frame_off();
        idle_chk();
        chk("result", result, 8'hff);
        host.frame_on();
        host.conv(8'h18, 16, got);
        chk("dout", got, 8'h5a);
        host.frame_off();
        $display("abort test done");
        rst_b = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        rst_b = 1'b1;
        idle_chk();
        chk("mux_sel", 8'(mux_sel), 8'h01);
        chk("result", result, 8'h00);
        host.frame_on();
        host.conv(8'h00, 16, got);
        chk("dout", got, 8'h00);
        host.frame_off();
        $display("mid-run reset test done");
        conclude();
    end

    initial
    begin
        repeat (3000) @(posedge clock);
        bad_count++;
        conclude();
    end
endmodule // quad_channel_adc_serial_control_tb
`default_nettype wire
